//--- rtl/hsp_pkg.sv
// package: constants, register map and carrier types for the strap/status pins
package hsp_pkg;
    localparam logic [11:0] HSP_OFF_CTRL = 12'h000;
    localparam logic [11:0] HSP_OFF_STRAP = 12'h004;
    localparam logic [11:0] HSP_OFF_CHG = 12'h008;
    localparam logic [11:0] HSP_OFF_STAT = 12'h00c;
    localparam int HSP_CTRL_STS_EN = 0;
    localparam int HSP_STRAP_GANGED = 0;
    localparam int HSP_STRAP_AUTO_N = 1;
    localparam int HSP_STRAP_PWR_N = 2;
    localparam int HSP_STRAP_BUS_N = 3;
    localparam int HSP_STRAP_LATCHED = 4;
    localparam int HSP_CHG_AUTO_DIS = 0;
    localparam int HSP_CHG_MASK_LSB = 4;
    localparam int HSP_SMB_ADDR_BIT = 2;
    localparam logic [31:0] HSP_CTRL_RST = 32'h0000_0000;
    localparam logic [3:0] HSP_CHG_MASK_RST = 4'hf;
    localparam int HSP_NPORTS = 4;

    typedef struct packed {
        logic ganged;
        logic auto_n;
        logic pwr_n;
        logic bus_n;
    } hsp_straps_t;

    typedef struct packed {
        logic pwr_ctl_en;
        logic ganged_mode;
        logic smbus_mode;
        logic [6:0] smb_addr_mask;
        logic auto_mode_en;
        logic port1_cdp_block;
    } hsp_mode_t;
endpackage

//--- rtl/hsp_strap_latch.sv
// strap capture: samples the strap levels once on the first enabled edge
// after reset release
`timescale 1ns/1ps
module hsp_strap_latch import hsp_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire hsp_straps_t pins,
    output hsp_straps_t straps,
    output logic latched
);
    typedef struct packed {
        hsp_straps_t s;
        logic done;
    } hsp_latch_state_t;

    hsp_latch_state_t st_r;
    hsp_latch_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        // capture at release, from a clocked process, never under reset
        if (!st_r.done) begin
            st_nxt.s = pins;
            st_nxt.done = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign straps = st_r.s;
    assign latched = st_r.done;

    chk_straps_frozen: assert property (
        @(posedge clk) disable iff (rst)
        latched && ce |=> straps == $past(straps))
        else $error("strap value changed after capture");
endmodule

//--- rtl/hsp_strap_pins.sv
// top: dual-function strap/status pins with an apb register window
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module hsp_strap_pins import hsp_pkg::*; #(
    parameter int NPORTS = HSP_NPORTS
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic GANGED_IN,
    output logic GANGED_OUT,
    output logic GANGED_OE,
    input wire logic AUTO_CHARGE_IN,
    output logic AUTO_CHARGE_OUT,
    output logic AUTO_CHARGE_OE,
    input wire logic POWER_SWITCHING_STRAP_N,
    input wire logic BUS_MODE_STRAP_N,
    input wire logic UPSTREAM_HISPEED_CONNECTED,
    input wire logic UPSTREAM_HISPEED_SUSPENDED,
    input wire logic UPSTREAM_CONNECTED,
    output logic PWR_CTL_EN,
    output logic GANGED_MODE,
    output logic SMBUS_MODE,
    output logic [6:0] SMB_ADDR_MASK,
    output logic AUTO_MODE_EN,
    output logic [NPORTS-1:0] CDP_ALLOWED
);
    typedef struct packed {
        logic status_output_enable;
        logic [3:0] chg_port_en;
        logic gang_out;
        logic gang_oe;
        logic auto_out;
        logic auto_oe;
        hsp_mode_t mode;
        logic [NPORTS-1:0] cdp;
        logic [31:0] rdata;
    } hsp_top_state_t;

    hsp_top_state_t st_r;
    hsp_top_state_t st_nxt;
    hsp_straps_t pins;
    hsp_straps_t straps;
    logic latched;

    // auto-charge pin is active low as a strap
    assign pins.ganged = GANGED_IN;
    assign pins.auto_n = AUTO_CHARGE_IN;
    assign pins.pwr_n = POWER_SWITCHING_STRAP_N;
    assign pins.bus_n = BUS_MODE_STRAP_N;

    hsp_strap_latch u_latch (
        .clk(SYS_CLK),
        .rst(RST),
        .ce(CE),
        .pins(pins),
        .straps(straps),
        .latched(latched)
    );

    function automatic logic is_addr(input logic [11:0] a,
                                     input logic [11:0] off);
        return a[11:2] == off[11:2];
    endfunction

    logic wr_en;
    logic rd_en;
    logic known;
    assign wr_en = PSEL && PENABLE && PWRITE && CE;
    assign rd_en = PSEL && !PENABLE && !PWRITE && CE;
    assign known = is_addr(PADDR, HSP_OFF_CTRL) ||
        is_addr(PADDR, HSP_OFF_STRAP) || is_addr(PADDR, HSP_OFF_CHG) ||
        is_addr(PADDR, HSP_OFF_STAT);

    always_comb begin
        st_nxt = st_r;
        if (wr_en && PSTRB[0]) begin
            if (is_addr(PADDR, HSP_OFF_CTRL)) begin
                st_nxt.status_output_enable = PWDATA[HSP_CTRL_STS_EN];
            end
            if (is_addr(PADDR, HSP_OFF_CHG)) begin
                st_nxt.chg_port_en = PWDATA[HSP_CHG_MASK_LSB +: 4];
            end
        end
        // power mode from latched straps
        st_nxt.mode.pwr_ctl_en = latched && !straps.pwr_n;
        st_nxt.mode.ganged_mode = latched && !straps.pwr_n &&
            straps.ganged;
        st_nxt.mode.smbus_mode = latched && !straps.bus_n;
        st_nxt.mode.smb_addr_mask = '0;
        if (latched && !straps.bus_n) begin
            st_nxt.mode.smb_addr_mask[HSP_SMB_ADDR_BIT] =
                straps.ganged;
        end
        // automatic mode only while the upstream side is unconnected
        st_nxt.mode.auto_mode_en = latched && !straps.auto_n &&
            !UPSTREAM_CONNECTED && (|st_r.chg_port_en);
        st_nxt.mode.port1_cdp_block = latched && !straps.auto_n;
        for (int i = 0; i < NPORTS; i++) begin
            st_nxt.cdp[i] = latched && UPSTREAM_CONNECTED &&
                (i < 4 ? st_r.chg_port_en[i % 4] : 1'b0);
        end
        if (latched && !straps.auto_n) begin
            st_nxt.cdp[0] = 1'b0;
        end
        // drivers stay off until straps are held and status is enabled
        st_nxt.gang_oe = latched && st_r.status_output_enable;
        st_nxt.auto_oe = latched && st_r.status_output_enable;
        st_nxt.gang_out = st_nxt.gang_oe &&
            UPSTREAM_HISPEED_CONNECTED;
        st_nxt.auto_out = st_nxt.auto_oe &&
            UPSTREAM_HISPEED_SUSPENDED;
        st_nxt.rdata = '0;
        if (rd_en) begin
            if (is_addr(PADDR, HSP_OFF_CTRL)) begin
                st_nxt.rdata[HSP_CTRL_STS_EN] = st_r.status_output_enable;
            end
            if (is_addr(PADDR, HSP_OFF_STRAP)) begin
                st_nxt.rdata[HSP_STRAP_GANGED] = straps.ganged;
                st_nxt.rdata[HSP_STRAP_AUTO_N] = straps.auto_n;
                st_nxt.rdata[HSP_STRAP_PWR_N] = straps.pwr_n;
                st_nxt.rdata[HSP_STRAP_BUS_N] = straps.bus_n;
                st_nxt.rdata[HSP_STRAP_LATCHED] = latched;
            end
            if (is_addr(PADDR, HSP_OFF_CHG)) begin
                st_nxt.rdata[HSP_CHG_AUTO_DIS] = straps.auto_n;
                st_nxt.rdata[HSP_CHG_MASK_LSB +: 4] = st_r.chg_port_en;
            end
            if (is_addr(PADDR, HSP_OFF_STAT)) begin
                st_nxt.rdata[0] = UPSTREAM_HISPEED_CONNECTED;
                st_nxt.rdata[1] = UPSTREAM_HISPEED_SUSPENDED;
                st_nxt.rdata[2] = UPSTREAM_CONNECTED;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            st_r <= '0;
            st_r.status_output_enable <= HSP_CTRL_RST[HSP_CTRL_STS_EN];
            st_r.chg_port_en <= HSP_CHG_MASK_RST;
        end else if (CE) begin
            st_r <= st_nxt;
        end
    end

    // read data is registered during setup, so access completes at once
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !known;
    assign PRDATA = st_r.rdata;
    assign GANGED_OUT = st_r.gang_out;
    assign GANGED_OE = st_r.gang_oe;
    assign AUTO_CHARGE_OUT = st_r.auto_out;
    assign AUTO_CHARGE_OE = st_r.auto_oe;
    assign PWR_CTL_EN = st_r.mode.pwr_ctl_en;
    assign GANGED_MODE = st_r.mode.ganged_mode;
    assign SMBUS_MODE = st_r.mode.smbus_mode;
    assign SMB_ADDR_MASK = st_r.mode.smb_addr_mask;
    assign AUTO_MODE_EN = st_r.mode.auto_mode_en;
    assign CDP_ALLOWED = st_r.cdp;

    chk_oe_in_reset: assert property (
        @(posedge SYS_CLK)
        RST |=> !GANGED_OE && !AUTO_CHARGE_OE)
        else $error("pin driven right after reset");

    chk_gang_status: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        CE && latched && st_r.status_output_enable ##1 CE |->
        GANGED_OUT == $past(UPSTREAM_HISPEED_CONNECTED))
        else $error("ganged pin not showing connection");

    chk_susp_status: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        CE && latched && st_r.status_output_enable |=>
        AUTO_CHARGE_OUT == $past(UPSTREAM_HISPEED_SUSPENDED))
        else $error("auto pin not showing suspend");

    chk_gang_mode: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        GANGED_MODE |-> PWR_CTL_EN && straps.ganged)
        else $error("ganged mode without switching");

    chk_indiv_mode: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        PWR_CTL_EN && !straps.ganged |-> !GANGED_MODE)
        else $error("individual mode lost");

    chk_smb_addr: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        SMBUS_MODE |-> SMB_ADDR_MASK[2] == straps.ganged)
        else $error("slave address bit 2 wrong");

    chk_smb_sel: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        SMBUS_MODE |-> !straps.bus_n)
        else $error("smbus mode with bus strap high");

    chk_auto_off: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        straps.auto_n |-> !AUTO_MODE_EN)
        else $error("auto mode with disable strap");

    // a frozen cycle keeps the old mode, so only look after an update
    chk_auto_upstrm: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        AUTO_MODE_EN && $past(CE) |->
        !$past(UPSTREAM_CONNECTED))
        else $error("auto mode while upstream connected");

    chk_no_cdp_p1: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        latched && !straps.auto_n ##1 CE |=> !CDP_ALLOWED[0])
        else $error("cdp on port 1 in auto mode");

    chk_chg_read: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        rd_en && is_addr(PADDR, HSP_OFF_CHG) |=>
        PRDATA[HSP_CHG_AUTO_DIS] == straps.auto_n)
        else $error("auto-disable bit does not match strap");

    // pin drivers
    chk_oe_latched: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        GANGED_OE |-> latched)
        else $error("ganged pin driven before capture");

    chk_auto_oe_latched: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        AUTO_CHARGE_OE |-> latched)
        else $error("auto pin driven before capture");

    chk_gang_idle: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        !GANGED_OE |-> !GANGED_OUT)
        else $error("ganged output high while released");

    chk_auto_idle: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        !AUTO_CHARGE_OE |-> !AUTO_CHARGE_OUT)
        else $error("auto output high while released");

    chk_oe_enable: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        CE && latched |=>
        GANGED_OE == $past(st_r.status_output_enable))
        else $error("ganged driver not following enable");

    chk_auto_oe_on: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        CE && latched |=>
        AUTO_CHARGE_OE == $past(st_r.status_output_enable))
        else $error("auto driver not following enable");

    chk_oe_pair: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        GANGED_OE == AUTO_CHARGE_OE)
        else $error("pin drivers out of step");

    // strap-derived modes
    chk_strap_latch: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        $rose(latched) |-> straps == $past(pins))
        else $error("captured straps differ from pins");

    chk_latch_once: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        latched |=> latched)
        else $error("capture flag dropped without reset");

    chk_freeze: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        !CE |=> $stable(GANGED_MODE) && $stable(PWR_CTL_EN))
        else $error("power mode moved while disabled");

    chk_pwr_latched: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        PWR_CTL_EN |-> latched)
        else $error("switching mode before capture");

    chk_pwr_mode: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        CE && latched |=> PWR_CTL_EN == !straps.pwr_n)
        else $error("switching mode does not match strap");

    chk_no_pwr_gang: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        !PWR_CTL_EN |-> !GANGED_MODE)
        else $error("gang mode without power switching");

    chk_ganged_sel: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        CE && latched |=>
        GANGED_MODE == (!straps.pwr_n && straps.ganged))
        else $error("gang mode does not match straps");

    chk_smb_latched: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        SMBUS_MODE |-> latched)
        else $error("bus mode before capture");

    chk_bus_mode: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        CE && latched |=> SMBUS_MODE == !straps.bus_n)
        else $error("bus mode does not match strap");

    chk_i2c_addr: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        !SMBUS_MODE |-> SMB_ADDR_MASK == 7'h00)
        else $error("address bits set outside smbus mode");

    chk_addr_bits: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        (SMB_ADDR_MASK & 7'h7b) == 7'h00)
        else $error("address bit other than 2 set");

    // charging
    chk_auto_strap: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        CE && latched && !straps.auto_n && !UPSTREAM_CONNECTED &&
        (|st_r.chg_port_en) |=> AUTO_MODE_EN)
        else $error("auto mode missing while unconnected");

    chk_auto_source: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        AUTO_MODE_EN |-> latched && !straps.auto_n)
        else $error("auto mode without captured strap");

    chk_auto_mask: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        AUTO_MODE_EN |-> CDP_ALLOWED == '0)
        else $error("cdp offered in auto mode");
endmodule

//--- test/hsp_board_model.sv
// board side of the shared pins: strap resistors, overridden by the device drivers
`timescale 1ns/1ps
module hsp_board_model (
    input wire logic ganged_strap,
    input wire logic auto_strap,
    input wire logic ganged_out,
    input wire logic ganged_oe,
    input wire logic auto_out,
    input wire logic auto_oe,
    output logic ganged_pin,
    output logic auto_pin
);
    // strap resistor wins only while the device leaves the pin released
    assign ganged_pin = ganged_oe ? ganged_out : ganged_strap;
    assign auto_pin = auto_oe ? auto_out : auto_strap;
endmodule

//--- test/hub_strap_status_pins_tb_top.sv
// self-checking bench for the strap/status pin block
`timescale 1ns/1ps
module hub_strap_status_pins_tb_top import hsp_pkg::*;;
    logic clk, rst, ce, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, g_strap, a_strap, pwr_n, bus_n, g_pin, a_pin;
    logic g_out, g_oe, a_out, a_oe, hs_conn, hs_susp, up_conn;
    logic pwr_en, ganged_mode, smbus, auto_en;
    logic [6:0] smb_mask;
    logic [3:0] cdp;
    int fail_count = 0;
    int checks = 0;

    hsp_strap_pins dut_u (.SYS_CLK(clk), .RST(rst), .CE(ce),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .GANGED_IN(g_pin), .GANGED_OUT(g_out),
        .GANGED_OE(g_oe), .AUTO_CHARGE_IN(a_pin), .AUTO_CHARGE_OUT(a_out),
        .AUTO_CHARGE_OE(a_oe), .POWER_SWITCHING_STRAP_N(pwr_n),
        .BUS_MODE_STRAP_N(bus_n), .UPSTREAM_HISPEED_CONNECTED(hs_conn),
        .UPSTREAM_HISPEED_SUSPENDED(hs_susp), .UPSTREAM_CONNECTED(up_conn),
        .PWR_CTL_EN(pwr_en), .GANGED_MODE(ganged_mode), .SMBUS_MODE(smbus),
        .SMB_ADDR_MASK(smb_mask), .AUTO_MODE_EN(auto_en), .CDP_ALLOWED(cdp));
    hsp_board_model board_u (.ganged_strap(g_strap), .auto_strap(a_strap),
        .ganged_out(g_out), .ganged_oe(g_oe), .auto_out(a_out),
        .auto_oe(a_oe), .ganged_pin(g_pin), .auto_pin(a_pin));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic summarize();
        if (fail_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // values read here are those the edge just sampled
        while (!pready && n < 20) begin
            n++;
            @(posedge clk);
        end
        if (n == 20) fail_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic do_reset(input logic [3:0] s);
        {g_strap, a_strap, pwr_n, bus_n} <= s;
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk({g_oe, a_oe}, 32'h0);
        @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic t_straps();
        logic [31:0] rd;
        logic e, g, a, p, b;
        logic [3:0] m;
        for (int i = 0; i < 16; i++) begin
            {g, a, p, b} = i[3:0];
            do_reset(i[3:0]);
            @(negedge clk);
            chk(pwr_en, !p);
            chk(ganged_mode, g & !p);
            chk(smbus, !b);
            chk(smb_mask, (!b && g) ? 7'h04 : 7'h00);
            chk(auto_en, !a);
            @(posedge clk);
            {g_strap, a_strap, pwr_n, bus_n} <= ~i[3:0];
            apb(1'b0, HSP_OFF_CHG, 32'h0, rd, e);
            chk(rd[HSP_CHG_AUTO_DIS], a);
            repeat (3) @(posedge clk);
            @(negedge clk);
            m = {!p, g & !p, !b, !a};
            chk({pwr_en, ganged_mode, smbus, auto_en}, m);
            @(posedge clk);
        end
    endtask

    task automatic t_status();
        logic [31:0] rd;
        logic e;
        do_reset(4'b0100);
        apb(1'b1, HSP_OFF_CTRL, 32'h1, rd, e);
        for (int i = 0; i < 4; i++) begin
            {hs_conn, hs_susp} <= i[1:0];
            repeat (3) @(posedge clk);
            @(negedge clk);
            chk({g_oe, a_oe}, 32'h3);
            chk(g_pin, i[1]);
            chk(a_pin, i[0]);
            @(posedge clk);
        end
        apb(1'b1, HSP_OFF_CTRL, 32'h0, rd, e);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk({g_oe, a_oe, g_pin, a_pin}, 32'h1);
        @(posedge clk);
    endtask

    task automatic t_cdp();
        for (int i = 0; i < 2; i++) begin
            do_reset({1'b0, i[0], 2'b00});
            up_conn <= 1'b1;
            repeat (3) @(posedge clk);
            @(negedge clk);
            chk(cdp, i[0] ? 4'hf : 4'he);
            chk(auto_en, 1'b0);
            @(posedge clk);
            up_conn <= 1'b0;
            repeat (3) @(posedge clk);
            @(negedge clk);
            chk(auto_en, !i[0]);
            @(posedge clk);
        end
    endtask

    task automatic t_err();
        logic [31:0] rd;
        logic e;
        apb(1'b0, 12'h010, 32'h0, rd, e);
        chk(e, 1'b1); // unmapped read refused
        chk(rd, 32'h0); // unmapped read returns zero
        apb(1'b0, HSP_OFF_CHG, 32'h0, rd, e);
        chk(rd[7:4], HSP_CHG_MASK_RST);
        apb(1'b0, HSP_OFF_STRAP, 32'h0, rd, e);
        chk(rd, 32'h12);
        apb(1'b0, HSP_OFF_STAT, 32'h0, rd, e);
        chk(rd, 32'h3);
        apb(1'b1, HSP_OFF_CHG, 32'h50, rd, e);
        apb(1'b0, HSP_OFF_CHG, 32'h0, rd, e);
        chk(rd, 32'h51);
        up_conn <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(cdp, 4'h5);
        @(posedge clk);
    endtask

    task automatic t_ce();
        logic [31:0] rd;
        logic e;
        ce <= 1'b0;
        apb(1'b1, HSP_OFF_CTRL, 32'h1, rd, e);
        ce <= 1'b1;
        apb(1'b0, HSP_OFF_CTRL, 32'h0, rd, e);
        chk(rd, 32'h0);
        chk({g_oe, a_oe}, 32'h0);
    endtask

    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = '1;
        {psel, penable, hs_conn, hs_susp, up_conn, g_strap, pwr_n} = '0;
        {a_strap, bus_n} = 2'b11;
        ce = 1'b1;
        @(posedge clk);
        t_straps();
        t_status();
        t_cdp();
        t_err();
        t_ce();
        summarize();
    end
    initial begin
        #500000;
        fail_count++;
        summarize();
    end
endmodule
